// ===== owd_consts.vh
`ifndef OWD_CONSTS_VH
`define OWD_CONSTS_VH
`define OWD_WORD_W 13
`define OWD_NUM_WORDS 3
// word 0 fields
`define OWD_W0_NOISE_WIDTH 11
`define OWD_W0_NOISE_REJECT 10
`define OWD_W0_RESET_PIN 9
`define OWD_W0_CYCLE_HI 8
`define OWD_W0_CYCLE_LO 7
`define OWD_W0_WDT_EN 6
`define OWD_W0_OSC_HI 5
`define OWD_W0_OSC_LO 3
`define OWD_W0_PROT_HI 2
`define OWD_W0_PROT_LO 0
// word 1 fields
`define OWD_W1_RC_SRC 12
`define OWD_W1_POWER_MODE 9
`define OWD_W1_TRIM_HI 8
`define OWD_W1_TRIM_LO 4
`define OWD_W1_RC_FREQ_HI 3
`define OWD_W1_RC_FREQ_LO 2
`define OWD_W1_LVR_HI 1
`define OWD_W1_LVR_LO 0
// word 2 fields
`define OWD_W2_SUB_TRIM_HI 12
`define OWD_W2_SUB_TRIM_LO 9
`define OWD_W2_TAG_HI 4
`define OWD_W2_TAG_LO 0
// reset (default) values of the decoded option words
`define OWD_W0_RESET 13'h0000
`define OWD_W1_RESET 13'h0400
`define OWD_W2_RESET 13'h0080
// oscillator modes
`define OWD_OSC_STD_CRYSTAL 3'h0
`define OWD_OSC_FAST_CRYSTAL 3'h1
`define OWD_OSC_LOW_CRYSTAL 3'h2
`define OWD_OSC_CRYSTAL_32K 3'h3
`define OWD_OSC_INT_RC_IO 3'h4
`define OWD_OSC_INT_RC_OUT 3'h5
`define OWD_OSC_EXT_RC_IO 3'h6
`define OWD_OSC_EXT_RC_OD 3'h7
// noise filter widths in oscillator periods
`define OWD_NOISE_LONG 32
`define OWD_NOISE_SHORT 8
// internal rc frequency codes
`define OWD_RC_4M 2'h0
`define OWD_RC_16M 2'h1
`define OWD_RC_8M 2'h2
// fuse array read: cycles allowed for data to settle per word
`define OWD_READ_WAIT 2
`endif

// ===== owd_option_word_decoder.v
// Operation
// - three 13-bit option words, not program-accessible
// - noise width: 32 periods at zero, 8 at one
// - filter bypassed in 32 kHz or sleep
// - falling-edge interrupt; filter on when bit zero
// - reset pin select: I/O or active-low reset
// - cycle length 00:4 01:2 10:8 11:16 clocks
// - watchdog enabled only when option bit one
// - three-bit oscillator mode field decode
// - internal RC codes set oscillator pin functions
// - external RC codes set input and outputs
// - protection field: ones enable, zeros disable
// - RC source: option word or runtime register
// - runtime frequency from bank 1 register 8
// - power mode: normal at zero, low at one
// - low-voltage reset off or 2.7/3.5/4.0 V
// - word two top bits trim sub oscillator
// - word two low bits are customer tag
`timescale 1ns/100ps
`include "owd_consts.vh"
module owd_option_word_decoder #(
  parameter WORD_W = `OWD_WORD_W,
  parameter READ_WAIT = `OWD_READ_WAIT
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst_b,
  // fuse array read port
  output wire [1:0] o_fuse_addr,
  output wire o_fuse_rd,
  input wire [WORD_W-1:0] i_fuse_data,
  // core hold
  output wire o_core_hold,
  output wire o_load_done,
  // runtime inputs
  input wire i_sleep,
  input wire [1:0] i_rc_freq_reg,
  // noise filter controls
  output reg o_int_filter_en,
  output reg [5:0] o_int_filter_len,
  // reset pin and core timing
  output reg o_reset_pin_is_reset,
  output reg [4:0] o_cycle_clocks,
  output reg o_wdt_en,
  // oscillator mode and pin functions
  output reg [2:0] o_osc_mode,
  output reg o_osc_pin_first_io,
  output reg o_osc_pin_first_rc_in,
  output reg o_osc_pin_second_io,
  output reg o_osc_pin_second_rc_out,
  output reg o_osc_pin_second_od,
  output reg o_osc_is_rc,
  // protection and power
  output reg o_protect_en,
  output reg o_low_power,
  // internal rc
  output reg o_rc_src_reg,
  output reg [1:0] o_rc_freq,
  output reg [4:0] o_rc_freq_mhz,
  output reg [4:0] o_rc_trim,
  // low voltage reset
  output reg o_lvr_en,
  output reg [1:0] o_lvr_level,
  // sub oscillator and id
  output reg [3:0] o_sub_osc_trim,
  output reg [4:0] o_customer_tag
);
  localparam ST_READ = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_DONE = 3'b100;

  reg [2:0] state;
  reg [1:0] word_idx;
  reg [1:0] wait_cnt;
  // option storage: flip-flops indexed by word number, no program path
  reg [WORD_W-1:0] opt_word [0:`OWD_NUM_WORDS-1];
  reg [2:0] next_state;
  wire [2:0] osc_f;
  wire [1:0] rc_code;
  // next values of the registered settings
  reg next_filter_en;
  reg [5:0] next_filter_len;
  reg next_reset_pin;
  reg [4:0] next_cycle_clocks;
  reg next_wdt_en;
  reg [2:0] next_osc_mode;
  reg next_first_io;
  reg next_first_rc_in;
  reg next_second_io;
  reg next_second_rc_out;
  reg next_second_od;
  reg next_is_rc;
  reg next_protect_en;
  reg next_low_power;
  reg next_rc_src_reg;
  reg [1:0] next_rc_freq;
  reg [4:0] next_rc_freq_mhz;
  reg [4:0] next_rc_trim;
  reg next_lvr_en;
  reg [1:0] next_lvr_level;
  reg [3:0] next_sub_osc_trim;
  reg [4:0] next_customer_tag;

  assign o_fuse_addr = word_idx;
  assign o_fuse_rd = (state != ST_DONE);
  // core held until every word is latched
  assign o_core_hold = (state != ST_DONE);
  assign o_load_done = (state == ST_DONE);

  always @* begin
    case (state)
      ST_READ: next_state = ST_WAIT;
      ST_WAIT: begin
        if (wait_cnt != READ_WAIT[1:0] - 2'h1) begin
          next_state = ST_WAIT;
        end else if (word_idx == 2'h2) begin
          next_state = ST_DONE;
        end else begin
          next_state = ST_READ;
        end
      end
      ST_DONE: next_state = ST_DONE;
      default: next_state = ST_READ;
    endcase
  end

  // words are only captured in the load sequence after reset
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      state <= ST_READ;
      word_idx <= 2'h0;
      wait_cnt <= 2'h0;
      opt_word[0] <= `OWD_W0_RESET;
      opt_word[1] <= `OWD_W1_RESET;
      opt_word[2] <= `OWD_W2_RESET;
    end else begin
      state <= next_state;
      if (state == ST_READ) begin
        wait_cnt <= 2'h0;
      end else if (state == ST_WAIT) begin
        wait_cnt <= wait_cnt + 2'h1;
        if (next_state != ST_WAIT) begin
          opt_word[word_idx] <= i_fuse_data;
          if (word_idx != 2'h2) begin
            word_idx <= word_idx + 2'h1;
          end
        end
      end
    end
  end

  assign osc_f = opt_word[0][`OWD_W0_OSC_HI:`OWD_W0_OSC_LO];
  // runtime frequency register bits 7:6 when source bit set
  assign rc_code = opt_word[1][`OWD_W1_RC_SRC] ? i_rc_freq_reg :
    opt_word[1][`OWD_W1_RC_FREQ_HI:`OWD_W1_RC_FREQ_LO];

  // decode registered so outputs stay stable; defaults until each word is latched
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_int_filter_en <= 1'b1;
      o_int_filter_len <= 6'h20;
      o_reset_pin_is_reset <= 1'b0;
      o_cycle_clocks <= 5'h04;
      o_wdt_en <= 1'b0;
      o_osc_mode <= `OWD_OSC_STD_CRYSTAL;
      o_osc_pin_first_io <= 1'b0;
      o_osc_pin_first_rc_in <= 1'b0;
      o_osc_pin_second_io <= 1'b0;
      o_osc_pin_second_rc_out <= 1'b0;
      o_osc_pin_second_od <= 1'b0;
      o_osc_is_rc <= 1'b0;
      o_protect_en <= 1'b0;
      o_low_power <= 1'b0;
      o_rc_src_reg <= 1'b0;
      o_rc_freq <= `OWD_RC_4M;
      o_rc_freq_mhz <= 5'h04;
      o_rc_trim <= 5'h00;
      o_lvr_en <= 1'b0;
      o_lvr_level <= 2'h0;
      o_sub_osc_trim <= 4'h0;
      o_customer_tag <= 5'h00;
    end else begin
      o_int_filter_en <= next_filter_en;
      o_int_filter_len <= next_filter_len;
      o_reset_pin_is_reset <= next_reset_pin;
      o_cycle_clocks <= next_cycle_clocks;
      o_wdt_en <= next_wdt_en;
      o_osc_mode <= next_osc_mode;
      o_osc_pin_first_io <= next_first_io;
      o_osc_pin_first_rc_in <= next_first_rc_in;
      o_osc_pin_second_io <= next_second_io;
      o_osc_pin_second_rc_out <= next_second_rc_out;
      o_osc_pin_second_od <= next_second_od;
      o_osc_is_rc <= next_is_rc;
      o_protect_en <= next_protect_en;
      o_low_power <= next_low_power;
      o_rc_src_reg <= next_rc_src_reg;
      o_rc_freq <= next_rc_freq;
      o_rc_freq_mhz <= next_rc_freq_mhz;
      o_rc_trim <= next_rc_trim;
      o_lvr_en <= next_lvr_en;
      o_lvr_level <= next_lvr_level;
      o_sub_osc_trim <= next_sub_osc_trim;
      o_customer_tag <= next_customer_tag;
    end
  end

  // words are preloaded by reset, so the decode shows the defaults until each word is latched
  always @* begin
    // the sleep input and, with the source bit set, i_rc_freq_reg stay live; everything else is fixed once the words are in
    next_filter_en = !opt_word[0][`OWD_W0_NOISE_REJECT] && !i_sleep &&
      (osc_f != `OWD_OSC_CRYSTAL_32K);
    if (opt_word[0][`OWD_W0_NOISE_WIDTH]) begin
      next_filter_len = 6'd`OWD_NOISE_SHORT;
    end else begin
      next_filter_len = 6'd`OWD_NOISE_LONG;
    end

    // core timing and supervision
    next_reset_pin = opt_word[0][`OWD_W0_RESET_PIN];
    case (opt_word[0][`OWD_W0_CYCLE_HI:`OWD_W0_CYCLE_LO])
      2'h0: next_cycle_clocks = 5'h04;
      2'h1: next_cycle_clocks = 5'h02;
      2'h2: next_cycle_clocks = 5'h08;
      default: next_cycle_clocks = 5'h10;
    endcase
    next_wdt_en = opt_word[0][`OWD_W0_WDT_EN];

    // crystal modes leave both pins to the oscillator
    next_osc_mode = osc_f;
    next_is_rc = osc_f[2];
    case (osc_f)
      `OWD_OSC_INT_RC_IO: begin
        next_first_io = 1'b1;
        next_first_rc_in = 1'b0;
        next_second_io = 1'b1;
        next_second_rc_out = 1'b0;
        next_second_od = 1'b0;
      end
      `OWD_OSC_INT_RC_OUT: begin
        next_first_io = 1'b1;
        next_first_rc_in = 1'b0;
        next_second_io = 1'b0;
        next_second_rc_out = 1'b1;
        next_second_od = 1'b0;
      end
      `OWD_OSC_EXT_RC_IO: begin
        next_first_io = 1'b0;
        next_first_rc_in = 1'b1;
        next_second_io = 1'b1;
        next_second_rc_out = 1'b0;
        next_second_od = 1'b0;
      end
      `OWD_OSC_EXT_RC_OD: begin
        next_first_io = 1'b0;
        next_first_rc_in = 1'b1;
        next_second_io = 1'b0;
        next_second_rc_out = 1'b1;
        next_second_od = 1'b1;
      end
      default: begin
        next_first_io = 1'b0;
        next_first_rc_in = 1'b0;
        next_second_io = 1'b0;
        next_second_rc_out = 1'b0;
        next_second_od = 1'b0;
      end
    endcase

    // protection and power
    // any set protect bit enables protection, the erased-safe reading
    next_protect_en = |opt_word[0][`OWD_W0_PROT_HI:`OWD_W0_PROT_LO];
    next_low_power = opt_word[1][`OWD_W1_POWER_MODE];

    // code 11 has no frequency of its own and falls back to the default
    next_rc_src_reg = opt_word[1][`OWD_W1_RC_SRC];
    next_rc_trim = opt_word[1][`OWD_W1_TRIM_HI:`OWD_W1_TRIM_LO];
    case (rc_code)
      `OWD_RC_16M: begin
        next_rc_freq = `OWD_RC_16M;
        next_rc_freq_mhz = 5'h10;
      end
      `OWD_RC_8M: begin
        next_rc_freq = `OWD_RC_8M;
        next_rc_freq_mhz = 5'h08;
      end
      default: begin
        next_rc_freq = `OWD_RC_4M;
        next_rc_freq_mhz = 5'h04;
      end
    endcase

    // low voltage reset, sub oscillator trim and customer tag
    next_lvr_en = |opt_word[1][`OWD_W1_LVR_HI:`OWD_W1_LVR_LO];
    next_lvr_level = opt_word[1][`OWD_W1_LVR_HI:`OWD_W1_LVR_LO];
    next_sub_osc_trim = opt_word[2][`OWD_W2_SUB_TRIM_HI:`OWD_W2_SUB_TRIM_LO];
    next_customer_tag = opt_word[2][`OWD_W2_TAG_HI:`OWD_W2_TAG_LO];
  end
endmodule

// ===== owd_props.sv
`timescale 1ns/100ps
module owd_props #(parameter WORD_W = 13) (
  // clock, reset and fuse port
  input wire i_clk,
  input wire i_rst_b,
  input wire [1:0] o_fuse_addr,
  input wire o_fuse_rd,
  input wire [WORD_W-1:0] i_fuse_data,
  input wire o_core_hold,
  input wire o_load_done,
  // decoded settings
  input wire i_sleep,
  input wire o_int_filter_en,
  input wire [5:0] o_int_filter_len,
  input wire [4:0] o_cycle_clocks,
  input wire o_osc_pin_second_od,
  input wire o_protect_en
);
  // shadow of word zero, taken whenever the decoder reads it
  reg [WORD_W-1:0] w0;
  always @(posedge i_clk) begin
    if (o_fuse_rd && o_fuse_addr == 2'h0)
      w0 <= i_fuse_data;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  a_hold_done_pair: assert property (o_load_done != o_core_hold)
    else $error("hold and done not complementary");
  a_done_sticks: assert property (o_load_done |=> o_load_done && !o_fuse_rd)
    else $error("load done dropped or fuse read again");
  a_load_bounded: assert property ($rose(i_rst_b) |-> ##[1:12] o_load_done)
    else $error("load did not finish in time");
  a_reset_view: assert property (disable iff (1'b0) !i_rst_b |=> o_core_hold && o_fuse_addr == 2'h0
    && o_int_filter_len == 6'h20 && o_cycle_clocks == 5'h04) else $error("reset defaults wrong");
  a_cycle_len: assert property (o_load_done && $past(o_load_done) |-> o_cycle_clocks ==
    (w0[8:7] == 2'h0 ? 5'h04 : w0[8:7] == 2'h1 ? 5'h02 : w0[8:7] == 2'h2 ? 5'h08 : 5'h10))
    else $error("cycle length decode wrong");
  a_filter_len: assert property (o_load_done && $past(o_load_done) |->
    o_int_filter_len == (w0[11] ? 6'h08 : 6'h20)) else $error("filter width wrong");
  a_filter_gate: assert property (o_load_done && $past(o_load_done) |-> o_int_filter_en ==
    (!w0[10] && w0[5:3] != 3'h3 && !$past(i_sleep))) else $error("filter enable wrong");
  a_od_pin: assert property (o_load_done && $past(o_load_done) |->
    o_osc_pin_second_od == (w0[5:3] == 3'h7)) else $error("open drain pin wrong");
  a_protect_any: assert property (o_load_done && $past(o_load_done) |->
    o_protect_en == (|w0[2:0])) else $error("protect decode wrong");
endmodule
bind owd_option_word_decoder owd_props #(.WORD_W(WORD_W)) u_props (.*);

// ===== owd_fuse_model.sv
`timescale 1ns/100ps
module owd_fuse_model (
  input wire i_clk,
  input wire [1:0] i_addr,
  input wire i_rd,
  output reg [12:0] o_data,
  input wire [38:0] i_words
);
  // not read: lines wander so a stale word is never mistaken for data
  always @(posedge i_clk) begin
    if (i_rd)
      o_data <= i_words[i_addr*13 +: 13];
    else
      o_data <= ~o_data;
  end
endmodule

// ===== test_owd_option_word_decoder.sv
`timescale 1ns/100ps
module test_owd_option_word_decoder;
  reg i_clk = 0, i_rst_b = 0, i_sleep = 0;
  reg [1:0] i_rc_freq_reg = 2'h0;
  reg [38:0] words = 39'h0;
  reg [2:0] b;
  wire [12:0] fd;
  wire [1:0] fa, lvl, rcf;
  wire [2:0] mode;
  wire frd, done, fen, rpin, wdt, prot, lowp, lvre, isrc, rsrc;
  wire [5:0] flen;
  wire [4:0] cyc, mhz, tag, pins, trim;
  wire [3:0] sub;
  integer fails = 0, samples_checked = 0, tick = 0, i, k;
  initial forever #20 i_clk = ~i_clk;
  owd_fuse_model fuse (.i_clk(i_clk), .i_addr(fa), .i_rd(frd), .o_data(fd), .i_words(words));
  owd_option_word_decoder DUT (.i_clk(i_clk), .i_rst_b(i_rst_b), .o_fuse_addr(fa), .o_fuse_rd(frd),
    .i_fuse_data(fd), .o_core_hold(), .o_load_done(done), .i_sleep(i_sleep), .i_rc_freq_reg(i_rc_freq_reg),
    .o_int_filter_en(fen), .o_int_filter_len(flen), .o_reset_pin_is_reset(rpin), .o_cycle_clocks(cyc),
    .o_wdt_en(wdt), .o_osc_mode(mode), .o_osc_pin_first_io(pins[4]), .o_osc_pin_first_rc_in(pins[3]),
    .o_osc_pin_second_io(pins[2]), .o_osc_pin_second_rc_out(pins[1]), .o_osc_pin_second_od(pins[0]),
    .o_osc_is_rc(isrc), .o_protect_en(prot), .o_low_power(lowp), .o_rc_src_reg(rsrc), .o_rc_freq(rcf),
    .o_rc_freq_mhz(mhz), .o_rc_trim(trim), .o_lvr_en(lvre), .o_lvr_level(lvl), .o_sub_osc_trim(sub),
    .o_customer_tag(tag));
  task chk(input [31:0] nm, input [7:0] seen, input [7:0] exp); begin
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("MISMATCH %0s expected %h seen %h", nm, exp, seen);
    end
  end endtask
  task tally_and_finish; begin
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  end endtask
  // reset with new fuse contents, then wait for load plus two more clock edges
  task load(input [38:0] w); begin
    words = w;
    i_rst_b = 0;
    repeat (4) @(posedge i_clk);
    #1 i_rst_b = 1;
    repeat (20) if (done !== 1'b1) begin @(posedge i_clk); #1; end
    repeat (2) @(posedge i_clk);
    #1;
    chk("done", done, 1);
  end endtask
  function [4:0] pin_of(input [2:0] m);
    pin_of = m == 3'h4 ? 5'h14 : m == 3'h5 ? 5'h12 : m == 3'h6 ? 5'h0c : m == 3'h7 ? 5'h0b : 5'h00;
  endfunction
  function [4:0] mhz_of(input [1:0] c);
    mhz_of = c == 2'h1 ? 5'h10 : c == 2'h2 ? 5'h08 : 5'h04;
  endfunction
  always @(posedge i_clk) begin
    tick = tick + 1;
    if (tick == 2000) begin
      fails = fails + 1;
      tally_and_finish;
    end
  end
  initial begin
    for (i = 0; i < 8; i = i + 1) begin
      b = i;
      load({1'b1, b, 4'h4, 2'h2, b,
        1'b0, 2'h1, b[0], 5'h00, b[1:0], b[1:0],
        1'b0, b[0], b[1], b[2], b[1:0], b[0], b, b});
      chk("cyc", cyc, b[1:0] == 0 ? 4 : b[1:0] == 1 ? 2 : b[1:0] == 2 ? 8 : 16);
      chk("flen", flen, b[0] ? 8 : 32);
      chk("fen", fen, !b[1] && b != 3);
      chk("rpin", rpin, b[2]);
      chk("wdt", wdt, b[0]);
      chk("pins", pins, pin_of(b));
      chk("mode", mode, b);
      chk("isrc", isrc, b[2]);
      chk("rsrc", rsrc, 0);
      chk("rcf", rcf, b[1:0] == 3 ? 0 : b[1:0]);
      chk("trim", trim, 0);
      chk("prot", prot, b != 0);
      chk("lowp", lowp, b[0]);
      chk("mhz", mhz, mhz_of(b[1:0]));
      chk("lvr", {lvre, lvl}, {b[1:0] != 0, b[1:0]});
      chk("sub", sub, {1'b1, b});
      chk("tag", tag, {2'h2, b});
      $display("test word set %0d end", i);
    end
    load({13'h0080, 13'h1400, 13'h0000});
    chk("rsrc", rsrc, 1);
    for (k = 0; k < 4; k = k + 1) begin
      i_rc_freq_reg = k[1:0];
      i_sleep = k[0];
      repeat (2) @(posedge i_clk);
      #1 chk("mhz", mhz, mhz_of(k[1:0]));
      chk("fen", fen, !k[0]);
      chk("rcf", rcf, k == 3 ? 0 : k);
    end
    words = ~words;
    repeat (3) @(posedge i_clk);
    #1 chk("cyc", cyc, 4);
    chk("done", done, 1);
    $display("test runtime source end");
    tally_and_finish;
  end
endmodule
